// ===== hw/hpw_host_port_consts.vh
`ifndef HPW_HOST_PORT_CONSTS_VH
`define HPW_HOST_PORT_CONSTS_VH

// clock and core timing
`define HPW_CLK_PERIOD_PS     10000
`define HPW_CORE_CLK_KHZ      58320
`define HPW_CORE_PER_PROC     2
`define HPW_PS_PER_MS         1000000000
`define HPW_PROC_CYC_PS       (`HPW_CORE_PER_PROC * `HPW_PS_PER_MS / `HPW_CORE_CLK_KHZ)

// least times round up, longest times round down
`define HPW_CEIL_CYC(n)       (((n) * `HPW_PROC_CYC_PS + `HPW_CLK_PERIOD_PS - 1) / `HPW_CLK_PERIOD_PS)
`define HPW_FLOOR_CYC(n)      (((n) * `HPW_PROC_CYC_PS) / `HPW_CLK_PERIOD_PS)

// wait lengths in processor cycles
`define HPW_INSTR_RD_MIN_PC   6
`define HPW_INSTR_RD_MAX_PC   7
`define HPW_RAM_RD_MIN_PC     9
`define HPW_INSTR_WR_MIN_PC   5
`define HPW_INSTR_WR_MAX_PC   7
`define HPW_RAM_WR_MIN_PC     9
`define HPW_RAM_WR_MAX_PC     29
`define HPW_THROTTLE_PC       97

// data ram access budget per frame
`define HPW_FRAME_NS          125000
`define HPW_FRAME_CYC         (`HPW_FRAME_NS * 1000 / `HPW_CLK_PERIOD_PS)
`define HPW_RAM_ACC_LIMIT     5'h10

// address decode
`define HPW_ADDR_W            11
`define HPW_DATA_W            8
`define HPW_ADDR_RAM_BIT      10
`define HPW_ADDR_INSTR_BIT    9

// access classes
`define HPW_CLS_REG           2'h0
`define HPW_CLS_INSTR         2'h1
`define HPW_CLS_RAM           2'h2

// pin index in the synchroniser vector
`define HPW_PIN_SEL           0
`define HPW_PIN_RD            1
`define HPW_PIN_WR            2

`endif

// ===== hw/hpw_host_port.v
`timescale 1ns/1ns
`include "hpw_host_port_consts.vh"

// Notes on behaviour
// - waits are counted in processor cycles of two core clock periods
// - ready driven high while group selected, released after select rises
// - ready pulled low after the strobe falls when the access needs a wait
// - instruction read holds ready low 6 to 7 cycles; register read none
// - data ram read holds ready low at least 9 processor cycles
// - read data valid by ready rising; register data shortly after strobe falls
// - instruction write 5 to 7 cycles, data ram write 9 to 29, register none
// - excessive data ram access stretches the wait up to 97 cycles
module hpw_host_port #(
  parameter FRAME_CYC = `HPW_FRAME_CYC
) (
  input  wire                     clock,
  input  wire                     rst_b,
  input  wire                     groupSelectN,
  input  wire                     rdN,
  input  wire                     wrN,
  input  wire [`HPW_ADDR_W-1:0]   addrIn,
  input  wire [`HPW_DATA_W-1:0]   dataIn,
  input  wire [`HPW_DATA_W-1:0]   rdDataIn,
  output reg  [`HPW_DATA_W-1:0]   dataOut_q,
  output reg                      dataOeN_q,
  output reg                      groupWaitReady_q,
  output reg                      groupWaitReadyOeN_q,
  output reg                      accReq_q,
  output reg                      accWrite_q,
  output reg  [1:0]               accClass_q,
  output reg  [`HPW_ADDR_W-1:0]   accAddr_q,
  output reg  [`HPW_DATA_W-1:0]   accWrData_q,
  output reg                      throttle_q
);

  localparam ST_IDLE = 4'h1;
  localparam ST_SEL  = 4'h2;
  localparam ST_WAIT = 4'h4;
  localparam ST_HOLD = 4'h8;

  localparam [31:0] WAIT_INSTR_RD_W = `HPW_CEIL_CYC(`HPW_INSTR_RD_MIN_PC);
  localparam [31:0] WAIT_RAM_RD_W   = `HPW_CEIL_CYC(`HPW_RAM_RD_MIN_PC);
  localparam [31:0] WAIT_INSTR_WR_W = `HPW_CEIL_CYC(`HPW_INSTR_WR_MIN_PC);
  localparam [31:0] WAIT_RAM_WR_W   = `HPW_CEIL_CYC(`HPW_RAM_WR_MIN_PC);
  localparam [31:0] WAIT_THROTTLE_W = `HPW_FLOOR_CYC(`HPW_THROTTLE_PC);
  localparam [31:0] FRAME_LAST_W    = FRAME_CYC - 1;
  // cut on purpose: every wait fits nine bits, a frame sixteen
  localparam [8:0]  WAIT_INSTR_RD   = WAIT_INSTR_RD_W[8:0];
  localparam [8:0]  WAIT_RAM_RD     = WAIT_RAM_RD_W[8:0];
  localparam [8:0]  WAIT_INSTR_WR   = WAIT_INSTR_WR_W[8:0];
  localparam [8:0]  WAIT_RAM_WR     = WAIT_RAM_WR_W[8:0];
  localparam [8:0]  WAIT_THROTTLE   = WAIT_THROTTLE_W[8:0];
  localparam [15:0] FRAME_LAST      = FRAME_LAST_W[15:0];

  // pin synchronisers: sel, rd, wr
  reg  [2:0]              pinS1_q;
  reg  [2:0]              pinS2_q;
  reg  [2:0]              pinS3_q;
  reg  [2:0]              pinF_q;
  wire [2:0]              pinF_d;
  // bus pipelines kept in step with the second sync stage
  reg  [`HPW_ADDR_W-1:0]  addrP1_q;
  reg  [`HPW_ADDR_W-1:0]  addrP2_q;
  reg  [`HPW_DATA_W-1:0]  dataP1_q;
  reg  [`HPW_DATA_W-1:0]  dataP2_q;
  reg  [`HPW_DATA_W-1:0]  wrHold_q;

  reg  [3:0]              state_q;
  reg  [8:0]              waitCnt_q;
  reg                     isWrite_q;
  reg                     capPend_q;
  reg  [15:0]             frameCnt_q;
  reg  [4:0]              ramCnt_q;

  reg  [1:0]              cls_d;
  reg  [8:0]              waitLen_d;

  wire                    selLow;
  wire                    rdFall;
  wire                    wrFall;
  wire                    wrRise;
  wire                    strobeFall;
  wire                    strobeHigh;
  wire                    frameEnd;
  wire                    ramStart;

  // a change counts once two later stages agree; otherwise keep the last value
  assign pinF_d = (pinS2_q & pinS3_q) | (pinF_q & (pinS2_q | pinS3_q));

  assign selLow     = ~pinF_q[`HPW_PIN_SEL];
  assign rdFall     = pinF_q[`HPW_PIN_RD] & ~pinF_d[`HPW_PIN_RD];
  assign wrFall     = pinF_q[`HPW_PIN_WR] & ~pinF_d[`HPW_PIN_WR];
  assign wrRise     = ~pinF_q[`HPW_PIN_WR] & pinF_d[`HPW_PIN_WR];
  assign strobeFall = rdFall | wrFall;
  assign strobeHigh = pinF_q[`HPW_PIN_RD] & pinF_q[`HPW_PIN_WR];
  assign frameEnd   = (frameCnt_q == FRAME_LAST);
  assign ramStart   = (state_q == ST_SEL) & selLow & strobeFall & (cls_d == `HPW_CLS_RAM);

  // class from the address that stood when the strobe fell
  always @* begin
    if (addrP2_q[`HPW_ADDR_RAM_BIT]) begin
      cls_d = `HPW_CLS_RAM;
    end else if (addrP2_q[`HPW_ADDR_INSTR_BIT]) begin
      cls_d = `HPW_CLS_INSTR;
    end else begin
      cls_d = `HPW_CLS_REG;
    end
  end

  // wait length in clocks, derived from processor cycles
  always @* begin
    waitLen_d = 9'h000;
    case (cls_d)
      `HPW_CLS_INSTR: begin
        waitLen_d = wrFall ? WAIT_INSTR_WR : WAIT_INSTR_RD;
      end
      `HPW_CLS_RAM: begin
        if (throttle_q) begin
          waitLen_d = WAIT_THROTTLE;
        end else begin
          waitLen_d = wrFall ? WAIT_RAM_WR : WAIT_RAM_RD;
        end
      end
      default: begin
        waitLen_d = 9'h000;
      end
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinS1_q  <= 3'h7;
      pinS2_q  <= 3'h7;
      pinS3_q  <= 3'h7;
      pinF_q   <= 3'h7;
      addrP1_q <= {`HPW_ADDR_W{1'b0}};
      addrP2_q <= {`HPW_ADDR_W{1'b0}};
      dataP1_q <= {`HPW_DATA_W{1'b0}};
      dataP2_q <= {`HPW_DATA_W{1'b0}};
    end else begin
      pinS1_q  <= {wrN, rdN, groupSelectN};
      pinS2_q  <= pinS1_q;
      pinS3_q  <= pinS2_q;
      pinF_q   <= pinF_d;
      addrP1_q <= addrIn;
      addrP2_q <= addrP1_q;
      dataP1_q <= dataIn;
      dataP2_q <= dataP1_q;
    end
  end

  // late write data is fine: sampled all through the low strobe
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrHold_q <= {`HPW_DATA_W{1'b0}};
    end else if (~pinS2_q[`HPW_PIN_WR] & ~pinS3_q[`HPW_PIN_WR]) begin
      wrHold_q <= dataP2_q;
    end
  end

  // data ram budget per frame; throttling ends with the frame
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frameCnt_q <= 16'h0000;
      ramCnt_q   <= 5'h00;
      throttle_q <= 1'b0;
    end else begin
      frameCnt_q <= frameEnd ? 16'h0000 : frameCnt_q + 16'h0001;
      if (frameEnd) begin
        // an access on the boundary is not lost: it opens the new budget
        ramCnt_q   <= ramStart ? 5'h01 : 5'h00;
        throttle_q <= 1'b0;
      end else if (ramStart) begin
        if (ramCnt_q != `HPW_RAM_ACC_LIMIT) begin
          ramCnt_q <= ramCnt_q + 5'h01;
        end
        if (ramCnt_q >= `HPW_RAM_ACC_LIMIT - 5'h01) begin
          throttle_q <= 1'b1;
        end
      end
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q             <= ST_IDLE;
      waitCnt_q           <= 9'h000;
      isWrite_q           <= 1'b0;
      capPend_q           <= 1'b0;
      groupWaitReady_q    <= 1'b0;
      groupWaitReadyOeN_q <= 1'b1;
      dataOut_q           <= {`HPW_DATA_W{1'b0}};
      dataOeN_q           <= 1'b1;
      accReq_q            <= 1'b0;
      accWrite_q          <= 1'b0;
      accClass_q          <= `HPW_CLS_REG;
      accAddr_q           <= {`HPW_ADDR_W{1'b0}};
      accWrData_q         <= {`HPW_DATA_W{1'b0}};
    end else begin
      accReq_q  <= 1'b0;
      capPend_q <= 1'b0;
      // internal memory must answer in the request cycle itself
      if (capPend_q) begin
        dataOut_q <= rdDataIn;
      end
      // drive the data bus only for a selected read
      dataOeN_q <= ~(selLow & ~pinF_q[`HPW_PIN_RD]);
      // a write goes in when its strobe rises, whatever the wait state
      if (wrRise & isWrite_q & (state_q != ST_IDLE)) begin
        accReq_q    <= 1'b1;
        accWrite_q  <= 1'b1;
        accWrData_q <= wrHold_q;
        isWrite_q   <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          groupWaitReadyOeN_q <= 1'b1;
          groupWaitReady_q    <= 1'b0;
          if (selLow) begin
            groupWaitReady_q    <= 1'b1;
            groupWaitReadyOeN_q <= 1'b0;
            state_q             <= ST_SEL;
          end
        end
        ST_SEL: begin
          if (!selLow) begin
            groupWaitReadyOeN_q <= 1'b1;
            groupWaitReady_q    <= 1'b0;
            state_q             <= ST_IDLE;
          end else if (strobeFall) begin
            accClass_q <= cls_d;
            accAddr_q  <= addrP2_q;
            isWrite_q  <= wrFall;
            if (rdFall) begin
              accReq_q   <= 1'b1;
              accWrite_q <= 1'b0;
              capPend_q  <= 1'b1;
            end
            if (waitLen_d != 9'h000) begin
              groupWaitReady_q <= 1'b0;
              waitCnt_q        <= waitLen_d;
              state_q          <= ST_WAIT;
            end else begin
              state_q <= ST_HOLD;
            end
          end
        end
        ST_WAIT: begin
          // ready rises 20 or more cycles after read data is already on the bus
          if (waitCnt_q == 9'h001) begin
            groupWaitReady_q <= 1'b1;
            state_q          <= ST_HOLD;
          end
          waitCnt_q <= waitCnt_q - 9'h001;
          if (!selLow) begin
            groupWaitReady_q    <= 1'b0;
            groupWaitReadyOeN_q <= 1'b1;
            waitCnt_q           <= 9'h000;
            state_q             <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (!selLow) begin
            groupWaitReady_q    <= 1'b0;
            groupWaitReadyOeN_q <= 1'b1;
            state_q             <= ST_IDLE;
          end else if (strobeHigh) begin
            state_q <= ST_SEL;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== bench/hpw_host_port_checker.sv
`timescale 1ns/1ns
`include "hpw_host_port_consts.vh"
module hpw_host_port_checker (
  input wire                   clock,
  input wire                   rst_b,
  input wire                   groupSelectN,
  input wire [`HPW_DATA_W-1:0] rdDataIn,
  input wire [`HPW_DATA_W-1:0] dataOut_q,
  input wire                   dataOeN_q,
  input wire                   groupWaitReady_q,
  input wire                   groupWaitReadyOeN_q,
  input wire                   accReq_q,
  input wire                   accWrite_q,
  input wire [1:0]             accClass_q,
  input wire [`HPW_ADDR_W-1:0] accAddr_q,
  input wire                   throttle_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire rdReq = accReq_q && !accWrite_q;
  // six cycles covers the three-stage synchroniser, the filter flop and the output flop
  sel_drive_a: assert property (!groupSelectN [*6] |-> !groupWaitReadyOeN_q)
    else $error("ready not driven while selected");
  sel_release_a: assert property (groupSelectN [*6] |-> groupWaitReadyOeN_q)
    else $error("ready not released");
  req_pulse_a: assert property (accReq_q |=> !accReq_q)
    else $error("request longer than one cycle");
  class_dec_a: assert property (accReq_q |-> accClass_q == (accAddr_q[`HPW_ADDR_RAM_BIT] ?
    `HPW_CLS_RAM : accAddr_q[`HPW_ADDR_INSTR_BIT] ? `HPW_CLS_INSTR : `HPW_CLS_REG))
    else $error("access class wrong");
  // memory answers in the request cycle, the capture lands one edge later
  rd_data_a: assert property (rdReq |=> dataOut_q == $past(rdDataIn))
    else $error("read data not captured");
  // the enable follows the filtered strobe, one edge behind the request
  rd_drive_a: assert property (rdReq |=> !dataOeN_q)
    else $error("data bus not driven on read");
  reg_rd_a: assert property (rdReq && accClass_q == `HPW_CLS_REG |-> groupWaitReady_q [*4])
    else $error("register read waited");
  instr_rd_a: assert property (rdReq && accClass_q == `HPW_CLS_INSTR
    |-> !groupWaitReady_q ##20 !groupWaitReady_q ##1 groupWaitReady_q)
    else $error("instruction read wait length");
  ram_rd_a: assert property (rdReq && accClass_q == `HPW_CLS_RAM && !throttle_q
    |-> !groupWaitReady_q ##30 !groupWaitReady_q ##1 groupWaitReady_q)
    else $error("ram read wait length");
  thr_rd_a: assert property (rdReq && accClass_q == `HPW_CLS_RAM && throttle_q
    && $past(throttle_q) |-> ##300 !groupWaitReady_q ##31 !groupWaitReady_q ##1 groupWaitReady_q)
    else $error("throttled wait length");
endmodule
bind hpw_host_port hpw_host_port_checker i_chk (.clock(clock), .rst_b(rst_b),
  .groupSelectN(groupSelectN), .rdDataIn(rdDataIn), .dataOut_q(dataOut_q),
  .dataOeN_q(dataOeN_q), .groupWaitReady_q(groupWaitReady_q),
  .groupWaitReadyOeN_q(groupWaitReadyOeN_q), .accReq_q(accReq_q), .accWrite_q(accWrite_q),
  .accClass_q(accClass_q), .accAddr_q(accAddr_q), .throttle_q(throttle_q));

// ===== bench/hpw_host_model.sv
`timescale 1ns/1ns
`include "hpw_host_port_consts.vh"
module hpw_host_model (
  input  wire                   clock,
  input  wire                   rdy,
  input  wire [`HPW_DATA_W-1:0] dBus,
  output reg                    groupSelectN,
  output reg                    rdN,
  output reg                    wrN,
  output reg  [`HPW_ADDR_W-1:0] addrIn,
  output reg  [`HPW_DATA_W-1:0] dataIn
);
  // above zero, the strobe is held that long whatever ready does
  int strobeMin = 0;
  initial begin
    groupSelectN = 1'h1;
    rdN = 1'h1;
    wrN = 1'h1;
    addrIn = 11'h000;
    dataIn = 8'h00;
  end
  // w comes back -1 when ready never settles
  task automatic access(input logic wr, input logic [10:0] a, input logic [7:0] d,
                        output int w, output logic [7:0] q);
    int n;
    begin
      w = 0;
      n = 0;
      @(negedge clock);
      addrIn = a;
      dataIn = ~d;
      groupSelectN = 1'h0;
      repeat (6) @(negedge clock);
      rdN = wr;
      wrN = !wr;
      while (n < 400 && !(rdy === 1'h1 && (w > 0 || n > 9) && n > strobeMin)) begin
        @(negedge clock);
        n++;
        if (rdy === 1'h0) w++;
        if (n == 3) dataIn = d;
      end
      if (n >= 400) w = -1;
      q = dBus;
      rdN = 1'h1;
      wrN = 1'h1;
      repeat (4) @(negedge clock);
      groupSelectN = 1'h1;
      repeat (60) @(negedge clock);
    end
  endtask
endmodule

// ===== bench/test_host_port_wait_handshake.sv
`timescale 1ns/1ns
`include "hpw_host_port_consts.vh"
module test_host_port_wait_handshake;
  localparam FRAME = 4000;
  reg        clock = 1'h0;
  reg        rst_b = 1'h0;
  reg  [7:0] memTog = 8'h00;
  reg  [7:0] wrSeen = 8'h00;
  reg  [7:0] q;
  wire [7:0] dataOut_q, accWrData_q, dataIn;
  wire [10:0] accAddr_q, addrIn;
  wire [1:0] accClass_q;
  wire       dataOeN_q, groupWaitReady_q, groupWaitReadyOeN_q, accReq_q, accWrite_q;
  wire       throttle_q, groupSelectN, rdN, wrN;
  // internal memory answers combinationally in the request cycle
  wire [7:0] rdDataIn = accReq_q ? accAddr_q[7:0] ^ 8'hA5 : memTog;
  // shared wait line has a pull-up; a released data bus shows garbage
  wire       rdy = groupWaitReadyOeN_q ? 1'h1 : groupWaitReady_q;
  wire [7:0] dBus = dataOeN_q ? ~dataOut_q : dataOut_q;
  int        error_cnt = 0;
  int        total_checks = 0;
  int        w;
  int        i;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    memTog <= ~memTog;
    if (accReq_q && accWrite_q) wrSeen <= accWrData_q;
  end
  hpw_host_port #(.FRAME_CYC(FRAME)) i_dut (.clock(clock), .rst_b(rst_b),
    .groupSelectN(groupSelectN), .rdN(rdN), .wrN(wrN), .addrIn(addrIn), .dataIn(dataIn),
    .rdDataIn(rdDataIn), .dataOut_q(dataOut_q), .dataOeN_q(dataOeN_q),
    .groupWaitReady_q(groupWaitReady_q), .groupWaitReadyOeN_q(groupWaitReadyOeN_q),
    .accReq_q(accReq_q), .accWrite_q(accWrite_q), .accClass_q(accClass_q),
    .accAddr_q(accAddr_q), .accWrData_q(accWrData_q), .throttle_q(throttle_q));
  hpw_host_model i_host (.clock(clock), .rdy(rdy), .dBus(dBus), .groupSelectN(groupSelectN),
    .rdN(rdN), .wrN(wrN), .addrIn(addrIn), .dataIn(dataIn));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task acc(input logic wr, input logic [10:0] a, input logic [7:0] d, input int expW);
    i_host.access(wr, a, d, w, q);
    if (w < 0) begin
      error_cnt++;
      print_verdict;
    end
    check(w, expW);
    check(wr ? wrSeen : q, wr ? d : a[7:0] ^ 8'hA5);
  endtask
  task t_reg;
    acc(1'h1, 11'h005, 8'h3C, 0);
    acc(1'h0, 11'h1FF, 8'h00, 0);
    $display("register access done");
  endtask
  task t_instr;
    acc(1'h1, 11'h200, 8'hC3, 18);
    acc(1'h0, 11'h3FF, 8'h00, 21);
    $display("instruction access done");
  endtask
  // host that does not wait on ready holds the strobe about 640 ns
  task t_blind;
    i_host.strobeMin = 64;
    acc(1'h0, 11'h2A0, 8'h00, 21);
    i_host.strobeMin = 0;
    $display("fixed wait access done");
  endtask
  task t_ram;
    acc(1'h0, 11'h400, 8'h00, 31);
    acc(1'h1, 11'h7FF, 8'h81, 31);
    $display("ram access done");
  endtask
  // two ram accesses already spent in this frame; overrun the budget
  task t_throttle;
    for (i = 0; i < 14; i++) acc(1'h0, 11'h410 + i, 8'h00, 31);
    check(throttle_q, 1);
    acc(1'h0, 11'h455, 8'h00, 332);
    repeat (FRAME) @(negedge clock);
    check(throttle_q, 0);
    acc(1'h0, 11'h466, 8'h00, 31);
    $display("throttle done");
  endtask
  initial begin
    repeat (2) @(negedge clock);
    rst_b = 1'h1;
    t_reg;
    t_instr;
    t_blind;
    t_ram;
    t_throttle;
    print_verdict;
  end
endmodule
